// ==== hdl/scep_programmer.sv ====
`timescale 1ns/1ps
`default_nettype none
module scep_programmer #(
  parameter int ADDR_BYTES           = 3,
  parameter int LEN_W                = 9,
  parameter int QUARTER_CYCLES       = scep_pkg::QUARTER_CYC,
  parameter int WRITE_TIMEOUT_CYCLES = scep_pkg::T_WR_CYC
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             prog_enable,
  input  wire logic             bus_select_bit,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire logic             cmd_read,
  input  wire logic [23:0]      cmd_addr,
  input  wire logic [LEN_W-1:0] cmd_len,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [7:0]       wr_data,
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic                  busy,
  output logic                  done,
  output logic                  nack_err,
  output logic                  timeout_err,
  output logic                  program_select_n,
  output logic                  scl_out,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe
);

  localparam int TW = $clog2(WRITE_TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TO_LIMIT = TW'(WRITE_TIMEOUT_CYCLES);
  localparam logic [1:0] ADDR_LAST = 2'(ADDR_BYTES - 1);

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_DEV, S_ADDR, S_WLOAD, S_WDATA, S_RSTART,
    S_RDEV, S_RDATA, S_STOP, S_PSTART, S_PDEV, S_DONE
  } scep_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic scep_tx_bit(input logic [7:0] b, input logic [3:0] i,
                                       input logic lsb_first);
    logic [2:0] k;
    k = i[2:0];
    return lsb_first ? b[k] : b[3'd7 - k];
  endfunction

  function automatic logic [7:0] scep_addr_byte(input logic [23:0] a, input logic [1:0] i);
    logic [23:0] s;
    s = a >> {i, 3'b000};
    return s[7:0];
  endfunction

  function automatic logic [7:0] scep_dev_byte(input logic sel, input logic rw);
    logic [7:0] b;
    b = scep_pkg::DEV_ADDR_BASE;
    b[scep_pkg::DEV_SEL_POS] = sel;
    b[scep_pkg::DEV_RW_POS]  = rw;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  scep_state_t       state_reg, state_next;
  logic [3:0]        bit_cnt_reg, bit_cnt_next;
  logic [7:0]        shift_reg, shift_next;
  logic [1:0]        addr_idx_reg, addr_idx_next;
  logic [LEN_W-1:0]  len_reg, len_next;
  logic [23:0]       addr_reg;
  logic              read_reg;
  logic              poll_reg, poll_next;
  logic              pend_reg, pend_next;
  logic              nack_reg, nack_next;
  logic              tout_reg, tout_next;
  logic              rd_valid_reg, rd_valid_next;
  logic [7:0]        rd_data_reg, rd_data_next;
  logic [TW-1:0]     wait_cnt_reg;
  logic              psel_n_reg;

  logic              op_valid;
  logic              op_ready;
  scep_pkg::scep_op_t op_code;
  logic              op_bit;
  logic              op_done;
  logic              rx_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire in_start  = (state_reg == S_START) || (state_reg == S_RSTART) || (state_reg == S_PSTART);
  wire in_stop   = (state_reg == S_STOP);
  wire in_tx     = (state_reg == S_DEV) || (state_reg == S_ADDR) || (state_reg == S_WDATA) ||
                   (state_reg == S_RDEV) || (state_reg == S_PDEV);
  wire in_rx     = (state_reg == S_RDATA);
  wire ack_slot  = (bit_cnt_reg == scep_pkg::ACK_SLOT);
  wire lsb_first = (state_reg == S_WDATA);
  wire last_byte = (len_reg <= LEN_W'(1));
  wire got_ack   = (rx_bit == scep_pkg::BIT_ACK);
  wire timed_out = (wait_cnt_reg >= TO_LIMIT);
  wire tx_bit    = scep_tx_bit(shift_reg, bit_cnt_reg, lsb_first);
  wire take_cmd  = cmd_valid && cmd_ready;

  assign op_valid = (in_start || in_stop || in_tx || in_rx) && !pend_reg;
  assign op_code  = in_start ? scep_pkg::OP_START :
                    in_stop  ? scep_pkg::OP_STOP  : scep_pkg::OP_BIT;
  assign op_bit   = in_tx ? (ack_slot ? 1'b1 : tx_bit) :
                    (ack_slot ? (last_byte ? scep_pkg::BIT_NACK : scep_pkg::BIT_ACK) : 1'b1);

  assign cmd_ready        = (state_reg == S_IDLE) && prog_enable && !psel_n_reg;
  assign wr_ready         = (state_reg == S_WLOAD);
  assign busy             = (state_reg != S_IDLE);
  assign done             = (state_reg == S_DONE);
  assign nack_err         = nack_reg;
  assign timeout_err      = tout_reg;
  assign rd_valid         = rd_valid_reg;
  assign rd_data          = rd_data_reg;
  assign program_select_n = psel_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    shift_next    = shift_reg;
    addr_idx_next = addr_idx_reg;
    len_next      = len_reg;
    poll_next     = poll_reg;
    nack_next     = nack_reg;
    tout_next     = tout_reg;
    rd_valid_next = 1'b0;
    rd_data_next  = rd_data_reg;
    pend_next     = pend_reg;
    if (op_valid && op_ready) begin
      pend_next = 1'b1;
    end else if (op_done) begin
      pend_next = 1'b0;
    end
    case (state_reg)
      S_IDLE: begin
        if (take_cmd) begin
          state_next = S_START;
          nack_next  = 1'b0;
          tout_next  = 1'b0;
          poll_next  = 1'b0;
          len_next   = cmd_len;
        end
      end
      S_START, S_RSTART, S_PSTART: begin
        if (op_done) begin
          bit_cnt_next = 4'h0;
          case (state_reg)
            S_START:  begin
              state_next = S_DEV;
              shift_next = scep_dev_byte(bus_select_bit, scep_pkg::RW_WRITE);
            end
            S_RSTART: begin
              state_next = S_RDEV;
              shift_next = scep_dev_byte(bus_select_bit, scep_pkg::RW_READ);
            end
            default:  begin
              state_next = S_PDEV;
              shift_next = scep_dev_byte(bus_select_bit, scep_pkg::RW_WRITE);
            end
          endcase
        end
      end
      S_WLOAD: begin
        if (wr_valid) begin
          state_next   = S_WDATA;
          shift_next   = wr_data;
          bit_cnt_next = 4'h0;
        end
      end
      S_DEV, S_ADDR, S_WDATA, S_RDEV, S_PDEV: begin
        if (op_done && !ack_slot) begin
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (op_done) begin
          bit_cnt_next = 4'h0;
          if (!got_ack && state_reg == S_PDEV) begin
            if (timed_out) begin
              tout_next  = 1'b1;
              state_next = S_STOP;
              poll_next  = 1'b0;
            end else begin
              state_next = S_PSTART;
            end
          end else if (!got_ack) begin
            nack_next  = 1'b1;
            state_next = S_STOP;
          end else begin
            case (state_reg)
              S_DEV: begin
                state_next    = S_ADDR;
                addr_idx_next = ADDR_LAST;
                shift_next    = scep_addr_byte(addr_reg, ADDR_LAST);
              end
              S_ADDR: begin
                if (addr_idx_reg != 2'd0) begin
                  addr_idx_next = addr_idx_reg - 2'd1;
                  shift_next    = scep_addr_byte(addr_reg, addr_idx_reg - 2'd1);
                end else begin
                  state_next = read_reg ? S_RSTART : S_WLOAD;
                end
              end
              S_WDATA: begin
                len_next = len_reg - LEN_W'(1);
                if (last_byte) begin
                  state_next = S_STOP;
                  poll_next  = 1'b1;
                end else begin
                  state_next = S_WLOAD;
                end
              end
              S_RDEV: state_next = S_RDATA;
              default: begin
                state_next = S_STOP;
                poll_next  = 1'b0;
              end
            endcase
          end
        end
      end
      S_RDATA: begin
        if (op_done && !ack_slot) begin
          shift_next[bit_cnt_reg[2:0]] = rx_bit;
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (op_done) begin
          bit_cnt_next  = 4'h0;
          rd_valid_next = 1'b1;
          rd_data_next  = shift_reg;
          len_next      = len_reg - LEN_W'(1);
          if (last_byte) begin
            state_next = S_STOP;
          end
        end
      end
      S_STOP: begin
        if (op_done) begin
          state_next = poll_reg ? S_PSTART : S_DONE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= S_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= scep_pkg::BYTE_RST;
      addr_idx_reg <= 2'd0;
      len_reg      <= '0;
      poll_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      nack_reg     <= 1'b0;
      tout_reg     <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= scep_pkg::BYTE_RST;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      shift_reg    <= shift_next;
      addr_idx_reg <= addr_idx_next;
      len_reg      <= len_next;
      poll_reg     <= poll_next;
      pend_reg     <= pend_next;
      nack_reg     <= nack_next;
      tout_reg     <= tout_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= 24'h000000;
      read_reg <= 1'b0;
    end else if (take_cmd) begin
      addr_reg <= cmd_addr;
      read_reg <= cmd_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle timer and mode select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt_reg <= '0;
    end else if (!poll_reg) begin
      wait_cnt_reg <= '0;
    end else if (!timed_out) begin
      wait_cnt_reg <= wait_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      psel_n_reg <= scep_pkg::PSEL_N_RST;
    end else begin
      psel_n_reg <= !(prog_enable || busy);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit engine
  scep_bit_engine #(
    .QUARTER_CYCLES (QUARTER_CYCLES)
  ) u_bit (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .op_valid (op_valid),
    .op_ready (op_ready),
    .op_code  (op_code),
    .op_bit   (op_bit),
    .op_done  (op_done),
    .rx_bit   (rx_bit),
    .scl_out  (scl_out),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe)
  );

endmodule
`default_nettype wire

// ==== shared/scep_pkg.sv ====
`default_nettype none
package scep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_RAW   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QUARTER_CYC   = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;
  localparam int T_WR_NS       = 10000000;
  localparam int T_WR_CYC      = T_WR_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Byte layout
  localparam logic [7:0] DEV_ADDR_BASE = 8'hA6;
  localparam int         DEV_SEL_POS   = 3;
  localparam int         DEV_RW_POS    = 0;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic       RW_WRITE      = 1'b0;
  localparam logic       RW_READ       = 1'b1;
  localparam logic       BIT_ACK       = 1'b0;
  localparam logic       BIT_NACK      = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic       SCL_RST       = 1'b1;
  localparam logic       PSEL_N_RST    = 1'b1;
  localparam logic [7:0] BYTE_RST      = 8'h00;

  typedef enum logic [1:0] {
    OP_START,
    OP_STOP,
    OP_BIT
  } scep_op_t;

endpackage
`default_nettype wire

// ==== hdl/scep_bit_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module scep_bit_engine #(
  parameter int QUARTER_CYCLES = scep_pkg::QUARTER_CYC
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire scep_pkg::scep_op_t op_code,
  input  wire logic              op_bit,
  output logic                   op_done,
  output logic                   rx_bit,
  output logic                   scl_out,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe
);

  localparam int CW = (QUARTER_CYCLES > 1) ? $clog2(QUARTER_CYCLES) : 1;
  localparam logic [CW-1:0] Q_LAST = CW'(QUARTER_CYCLES - 1);

  logic               sda_meta_reg;
  logic               sda_sync_reg;
  logic               busy_reg;
  logic [1:0]         phase_reg;
  logic [CW-1:0]      cnt_reg;
  scep_pkg::scep_op_t op_reg;
  logic               scl_reg, scl_next;
  logic               oe_reg, oe_next;
  logic               rx_reg, rx_next;
  logic               done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter period sequencing
  wire accept   = op_valid && !busy_reg;
  wire q_end    = busy_reg && (cnt_reg == Q_LAST);
  wire is_start = (op_reg == scep_pkg::OP_START);
  wire is_stop  = (op_reg == scep_pkg::OP_STOP);

  assign op_ready = !busy_reg;
  assign op_done  = done_reg;
  assign rx_bit   = rx_reg;
  assign scl_out  = scl_reg;
  assign sda_out  = 1'b0;
  assign sda_oe   = oe_reg;

  always_comb begin
    scl_next = scl_reg;
    oe_next  = oe_reg;
    rx_next  = rx_reg;
    if (accept) begin
      case (op_code)
        scep_pkg::OP_START: oe_next = 1'b0;
        scep_pkg::OP_STOP:  oe_next = 1'b1;
        default:            oe_next = !op_bit;
      endcase
    end else if (q_end) begin
      case (phase_reg)
        2'd0: scl_next = 1'b1;
        2'd1: begin
          if (is_start) begin
            oe_next = 1'b1;
          end else if (is_stop) begin
            oe_next = 1'b0;
          end else begin
            rx_next = sda_sync_reg;
          end
        end
        2'd2: begin
          if (!is_stop) begin
            scl_next = 1'b0;
          end
        end
        default: scl_next = scl_reg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg  <= 1'b0;
      phase_reg <= 2'd0;
      cnt_reg   <= '0;
      op_reg    <= scep_pkg::OP_STOP;
      scl_reg   <= scep_pkg::SCL_RST;
      oe_reg    <= 1'b0;
      rx_reg    <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      scl_reg  <= scl_next;
      oe_reg   <= oe_next;
      rx_reg   <= rx_next;
      done_reg <= q_end && (phase_reg == 2'd3);
      if (accept) begin
        busy_reg  <= 1'b1;
        phase_reg <= 2'd0;
        cnt_reg   <= '0;
        op_reg    <= op_code;
      end else if (q_end) begin
        cnt_reg   <= '0;
        phase_reg <= phase_reg + 2'd1;
        busy_reg  <= (phase_reg != 2'd3);
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== tb/scep_prog_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module scep_prog_sva #(
  parameter int QUARTER_CYCLES = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic prog_enable,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic nack_err,
  input wire logic program_select_n,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic        scl_reg;
  logic [15:0] run_reg;
  wire  logic  run_sat;
  assign run_sat = (run_reg == 16'hFFFF);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Cycles spent at the current clock level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_reg <= 1'b1;
      run_reg <= 16'hFFFF;
    end else begin
      scl_reg <= scl_out;
      run_reg <= (scl_out != scl_reg) ? 16'h0001 : (run_sat ? run_reg : run_reg + 16'h0001);
    end
  end
  ////////////////////////////////////////
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data line driven high");
  property p_scl_run; scl_out != scl_reg |-> run_reg >= 16'(2 * QUARTER_CYCLES); endproperty
  a_scl_run: assert property (p_scl_run) else $error("clock level too short");
  property p_hold; $rose(scl_out) |=> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("data moved after clock rise");
  property p_idle; !busy |-> scl_out && !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("lines not idle");
  property p_psel; busy |-> !program_select_n; endproperty
  a_psel: assert property (p_psel) else $error("select high while busy");
  property p_ready; cmd_ready |-> prog_enable && !busy && !program_select_n; endproperty
  a_ready: assert property (p_ready) else $error("ready without select");
  property p_done; done |=> !done && !busy; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_wr; wr_ready |-> busy && !scl_out; endproperty
  a_wr: assert property (p_wr) else $error("clock high while waiting data");
  c_take: cover property (cmd_valid && cmd_ready);
  c_read: cover property (rd_valid);
  c_nack: cover property ($rose(nack_err));
endmodule
bind scep_programmer scep_prog_sva #(.QUARTER_CYCLES(QUARTER_CYCLES)) scep_prog_sva_inst (
  .clk(clk), .sys_rst(sys_rst), .prog_enable(prog_enable), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .wr_ready(wr_ready), .rd_valid(rd_valid), .busy(busy), .done(done), .nack_err(nack_err),
  .program_select_n(program_select_n), .scl_out(scl_out), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ==== tb/scep_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scep_dev_model #(
  parameter int ADDR_BYTES = 3,
  parameter int WR_NS      = 20000
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic program_select_n,
  input  wire logic bus_select_pin,
  output logic      sda_pull
);
  logic [7:0]  mem [0:255];
  logic [7:0]  sh;
  logic [7:0]  txb;
  logic [23:0] addr;
  int          nbit;
  int          nbyte;
  logic        sel, rd, tx, wrote, wbusy;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    sda_pull = 1'b0;
    sel = 1'b0;
    wrote = 1'b0;
    wbusy = 1'b0;
  end
  ////////////////////////////////////////
  // Start and stop; only seen while program_select_n is low
  always @(negedge sda) begin
    if (scl && !program_select_n) begin
      sel = !wbusy;
      tx = 1'b0;
      nbit = 0;
      nbyte = 0;
    end
  end
  always @(posedge sda) begin
    if (scl && !program_select_n && !wbusy) begin
      sel = 1'b0;
      if (wrote) begin
        wrote = 1'b0;
        wbusy = 1'b1;
        #WR_NS;
        wbusy = 1'b0;
      end
    end
  end
  ////////////////////////////////////////
  // Received byte handling
  task automatic take_byte;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) d[i] = sh[7 - i];
    if (nbyte == 0) begin
      sel = ({sh[7:4], sh[2:1]} == 6'h2B) && (sh[3] == bus_select_pin);
      rd = sh[0];
    end else if (nbyte <= ADDR_BYTES) begin
      addr = {addr[15:0], sh};
    end else begin
      mem[addr[7:0]] = d;
      addr[5:0] = addr[5:0] + 6'h01;
      wrote = 1'b1;
    end
  endtask
  always @(posedge scl) begin
    if (sel) begin
      if (nbit == 8) begin
        if (tx && sda) sel = 1'b0;
        else if (tx) addr = addr + 24'h000001;
        if (nbyte == 0 && rd) tx = 1'b1;
        txb = mem[addr[7:0]];
        nbit = 0;
        nbyte++;
      end else begin
        sh = {sh[6:0], sda};
        nbit++;
        if (nbit == 8 && !tx) take_byte();
      end
    end
  end
  always @(negedge scl) begin
    #1;
    if (!sel) sda_pull = 1'b0;
    else if (nbit == 8) sda_pull = !tx;
    else if (tx) sda_pull = !txb[nbit];
    else sda_pull = 1'b0;
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int Q   = 2;
  localparam int TMO = 5000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        prog_enable = 1'b0;
  logic        bus_select_bit = 1'b1;
  logic        dev_pin = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_read = 1'b0;
  logic [23:0] cmd_addr = 24'h000000;
  logic [8:0]  cmd_len = 9'h001;
  logic        wr_valid = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic        cmd_ready, wr_ready, rd_valid, busy, done, nack_err, timeout_err;
  logic        program_select_n, scl_out, sda_out, sda_oe, dev_pull;
  logic [7:0]  rd_data;
  logic [7:0]  wbuf [0:3];
  logic [7:0]  rbuf [0:3];
  int          errors = 0;
  int          checks = 0;
  int          nr;
  wire  logic  sda_line;
  assign sda_line = ((sda_oe && !sda_out) || dev_pull) ? 1'b0 : 1'b1;
  always #50 clk = ~clk;
  scep_programmer #(.QUARTER_CYCLES(Q), .WRITE_TIMEOUT_CYCLES(2000)) scep_programmer_inst (
    .clk(clk), .sys_rst(sys_rst), .prog_enable(prog_enable), .bus_select_bit(bus_select_bit),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .busy(busy), .done(done), .nack_err(nack_err), .timeout_err(timeout_err),
    .program_select_n(program_select_n), .scl_out(scl_out), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
  scep_dev_model scep_dev_model_inst (
    .scl(scl_out), .sda(sda_line), .program_select_n(program_select_n), .bus_select_pin(dev_pin), .sda_pull(dev_pull));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #10;
  endtask
  task automatic run_cmd(input logic rd, input logic [23:0] a, input logic [8:0] n);
    int   g;
    int   k;
    logic tk;
    g = 0;
    k = 0;
    nr = 0;
    cmd_read = rd;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && g < TMO) begin
      step();
      g++;
    end
    step();
    cmd_valid = 1'b0;
    wr_data = wbuf[0];
    wr_valid = !rd;
    while (done !== 1'b1 && g < TMO) begin
      tk = (wr_ready === 1'b1);
      if (rd_valid === 1'b1 && nr < 4) begin
        rbuf[nr] = rd_data;
        nr++;
      end
      step();
      g++;
      if (tk && k < 3) begin
        k++;
        wr_data = wbuf[k];
      end
    end
    wr_valid = 1'b0;
    if (g >= TMO) begin
      errors++;
      summarize();
    end
  endtask
  ////////////////////////////////////////
  task automatic s_reset;
    repeat (16) step();
    check(scl_out, 1'b1);
    check(sda_oe, 1'b0);
    sys_rst = 1'b0;
    repeat (3) step();
    check(cmd_ready, 1'b0);
    check(program_select_n, 1'b1);
    prog_enable = 1'b1;
    repeat (2) step();
    check(program_select_n, 1'b0);
  endtask
  task automatic s_write_wrap;
    wbuf[0] = 8'h1C;
    wbuf[1] = 8'h35;
    wbuf[2] = 8'hC2;
    wbuf[3] = 8'h00;
    run_cmd(1'b0, 24'h00007E, 9'h003);
    check(nack_err, 1'b0);
    check(timeout_err, 1'b0);
    check(scep_dev_model_inst.wbusy, 1'b0);
    check(scep_dev_model_inst.mem[8'h7E], 8'h1C);
    check(scep_dev_model_inst.mem[8'h7F], 8'h35);
    check(scep_dev_model_inst.mem[8'h40], 8'hC2);
  endtask
  task automatic s_read_stream;
    run_cmd(1'b1, 24'h00007E, 9'h003);
    check(nr[7:0], 8'h03);
    check(rbuf[0], 8'h1C);
    check(rbuf[1], 8'h35);
    check(rbuf[2], 8'h00);
    run_cmd(1'b1, 24'h000040, 9'h001);
    check(rbuf[0], 8'hC2);
    check(nack_err, 1'b0);
  endtask
  task automatic s_timeout;
    int g;
    g = 0;
    wbuf[0] = 8'h77;
    fork
      run_cmd(1'b0, 24'h000020, 9'h001);
      begin
        while (scep_dev_model_inst.wbusy !== 1'b1 && g < TMO) begin
          step();
          g++;
        end
        dev_pin = 1'b0;
      end
    join
    check(timeout_err, 1'b1);
    check(nack_err, 1'b0);
    check(scep_dev_model_inst.mem[8'h20], 8'h77);
    dev_pin = 1'b1;
  endtask
  task automatic s_bad_select;
    bus_select_bit = 1'b0;
    wbuf[0] = 8'h5A;
    run_cmd(1'b0, 24'h000010, 9'h001);
    check(nack_err, 1'b1);
    check(scep_dev_model_inst.mem[8'h10], 8'h00);
    bus_select_bit = 1'b1;
    run_cmd(1'b1, 24'h000010, 9'h001);
    check(nack_err, 1'b0);
    check(rbuf[0], 8'h00);
    prog_enable = 1'b0;
    repeat (3) step();
    check(program_select_n, 1'b1);
  endtask
  initial begin
    s_reset();
    s_write_wrap();
    s_read_stream();
    s_timeout();
    s_bad_select();
    summarize();
  end
endmodule
`default_nettype wire
